/* mfe_front_end.sv */
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Function
// - narrow burst writes pack 2/4/8 words
// - packed words sit on master boundaries
// - filler words one per cycle, waitreq high
// - read split to free read buffer room
// - writes over half buffer are split
// - master byte address, 8 to 40 bits
// - outstanding reads never exceed maximum
// - control register flushes cached ports
// - starvation control for all but top
// - no starvation control: strict priority
// - boost one level after limit services
// - limit counts services to any other level
// - up to 26 independent slave ports
// - port is cached, burst, or absent
// - doubled cached port is twice wide
// - forced reload bypasses the cache
// - burst ports have read/write fifo depth
// - only burst ports may be narrower
// - five levels, highest served first
// - same level sampled, served in batches
// - boost clears counter, ends after service
module mfe_front_end
    import mfe_pkg::*;
#(
    parameter int NPORTS = 4,
    parameter int AW = 32,
    parameter int DW = 64,
    parameter int LW = 8,
    parameter int BUF_WORDS = 64,
    parameter int MAX_PEND = 16,
    parameter logic [2*NPORTS-1:0] PORT_TYPE = {NPORTS{MFE_PT_BURST}},
    parameter logic [3*NPORTS-1:0] PORT_LEVEL = '0,
    parameter logic [2*NPORTS-1:0] PORT_RATIO = '0,
    parameter logic [NPORTS-1:0] DOUBLE_W = '0,
    parameter logic [NPORTS-1:0] FORCE_RELOAD = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORTS-1:0] port_req,
    input wire logic [NPORTS-1:0] port_rd,
    input wire logic [NPORTS-1:0] port_hit,
    input wire logic [NPORTS*AW-1:0] port_addr,
    input wire logic [NPORTS*LW-1:0] port_len,
    input wire logic [NPORTS*LW-1:0] port_room,
    output logic [NPORTS-1:0] port_grant,
    output logic [LW-1:0] port_chunk,
    output logic [NPORTS-1:0] port_waitreq,
    output logic [NPORTS-1:0] port_flush,
    output logic [AW-1:0] am_addr,
    output logic am_rd,
    output logic am_wr,
    output logic [LW-1:0] am_burstcount,
    output logic am_burststart,
    input wire logic am_waitreq,
    input wire logic am_datavalid
);
    localparam int MBL = $clog2(DW / 8);
    localparam int HALF_BUF = BUF_WORDS / 2;
    localparam int PW = $clog2(MAX_PEND + 1);

    mfe_state_e state_reg;
    logic [NPORTS-1:0] samp_reg [MFE_LEVELS];
    logic [MFE_LIM_W-1:0] cnt_reg [MFE_LEVELS];
    logic [MFE_BOOST_W-1:0] boost_reg [MFE_LEVELS];
    logic [3:0] starv_en_reg;
    logic [31:0] limit_reg;
    logic [PW-1:0] pend_reg;
    logic [LW-1:0] fill_reg;
    logic [LW-1:0] beats_reg;
    logic [31:0] grants_reg;
    logic [NPORTS-1:0] lvl_mask [MFE_LEVELS];
    logic [NPORTS-1:0] present, cached, elig;
    logic [NPORTS-1:0] batch [MFE_LEVELS];
    logic [NPORTS-1:0] batch_sel, sel_oh;
    logic [MFE_BOOST_W-1:0] best_eff;
    logic [2:0] best_lvl;
    logic found, fits, grant, is_rd;
    int sel, rl, off, len, mw, cap, chunk_m, gl, fill;
    logic apb_acc, apb_done;

    // a port of no type or an out-of-range count never requests
    always_comb begin
        for (int l = 0; l < MFE_LEVELS; l++) begin
            lvl_mask[l] = '0;
        end
        for (int p = 0; p < NPORTS; p++) begin
            present[p] = (PORT_TYPE[2*p +: 2] != MFE_PT_NONE) && (p < MFE_MAX_PORTS);
            cached[p] = (PORT_TYPE[2*p +: 2] == MFE_PT_CACHED);
            lvl_mask[PORT_LEVEL[3*p +: 3]][p] = 1'b1;
        end
    end

    // a cache read hit needs no memory unless reload is forced
    assign elig = port_req & present & ~(port_hit & port_rd & cached & ~FORCE_RELOAD);

    // boosted levels win ties at their raised priority
    always_comb begin
        best_eff = '1;
        best_lvl = 3'h0;
        found = 1'b0;
        batch_sel = '0;
        for (int l = 0; l < MFE_LEVELS; l++) begin
            batch[l] = ((samp_reg[l] & elig) != '0) ? (samp_reg[l] & elig)
                                                    : (elig & lvl_mask[l]);
            if (batch[l] != '0 && (!found
                    || (MFE_BOOST_W'(l) - boost_reg[l]) < best_eff
                    || ((MFE_BOOST_W'(l) - boost_reg[l]) == best_eff
                        && boost_reg[l] != '0))) begin
                found = 1'b1;
                best_eff = MFE_BOOST_W'(l) - boost_reg[l];
                best_lvl = 3'(l);
                batch_sel = batch[l];
            end
        end
    end

    always_comb begin
        sel = 0;
        sel_oh = '0;
        for (int p = NPORTS - 1; p >= 0; p--) begin
            if (batch_sel[p]) begin
                sel = p;
            end
        end
        sel_oh[sel] = found;
    end

    // narrow ports pack 1<<rl slave words per master word
    always_comb begin
        is_rd = port_rd[sel];
        rl = (PORT_TYPE[2*sel +: 2] == MFE_PT_BURST) ? int'(PORT_RATIO[2*sel +: 2]) : 0;
        if (rl > MBL) begin
            rl = MBL;
        end
        off = int'(port_addr[sel*AW +: MBL]) >> (MBL - rl);
        len = int'(port_len[sel*LW +: LW]);
        if (DOUBLE_W[sel] && cached[sel]) begin
            mw = len * 2;
        end else begin
            mw = (off + len + (1 << rl) - 1) >> rl;
        end
        if (is_rd) begin
            cap = int'(port_room[sel*LW +: LW]);
            if (MAX_PEND - int'(pend_reg) < cap) begin
                cap = MAX_PEND - int'(pend_reg);
            end
        end else begin
            cap = HALF_BUF;
        end
        chunk_m = (mw < cap) ? mw : cap;
        if (DOUBLE_W[sel] && cached[sel]) begin
            gl = chunk_m / 2;
            fill = 0;
        end else begin
            gl = ((chunk_m << rl) - off < len) ? (chunk_m << rl) - off : len;
            fill = is_rd ? 0 : (chunk_m << rl) - gl;
        end
        fits = (chunk_m > 0) && (gl > 0);
        grant = (state_reg == MFE_ST_IDLE) && found && fits;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MFE_ST_IDLE;
            fill_reg <= '0;
            beats_reg <= '0;
            am_addr <= '0;
            am_rd <= 1'b0;
            am_wr <= 1'b0;
            am_burstcount <= '0;
            am_burststart <= 1'b0;
            port_waitreq <= '0;
        end else begin
            case (state_reg)
                MFE_ST_IDLE: begin
                    if (grant) begin
                        // master word aligned byte address
                        am_addr <= {port_addr[sel*AW + MBL +: AW - MBL], MBL'(0)};
                        am_burstcount <= LW'(chunk_m);
                        beats_reg <= LW'(chunk_m);
                        fill_reg <= LW'(fill);
                        if (fill > 0) begin
                            state_reg <= MFE_ST_ALIGN;
                            port_waitreq <= sel_oh;
                        end else begin
                            state_reg <= MFE_ST_CMD;
                            am_rd <= is_rd;
                            am_wr <= !is_rd;
                            am_burststart <= 1'b1;
                        end
                    end
                end
                MFE_ST_ALIGN: begin
                    // one filler word per cycle
                    fill_reg <= fill_reg - LW'(1);
                    if (fill_reg == LW'(1)) begin
                        state_reg <= MFE_ST_CMD;
                        port_waitreq <= '0;
                        am_wr <= 1'b1;
                        am_burststart <= 1'b1;
                    end
                end
                MFE_ST_CMD: begin
                    if (!am_waitreq) begin
                        am_burststart <= 1'b0;
                        beats_reg <= beats_reg - LW'(1);
                        if (am_rd || beats_reg == LW'(1)) begin
                            state_reg <= MFE_ST_IDLE;
                            am_rd <= 1'b0;
                            am_wr <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= MFE_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_grant <= '0;
            port_chunk <= '0;
            grants_reg <= '0;
        end else begin
            port_grant <= grant ? sel_oh : '0;
            if (grant) begin
                port_chunk <= LW'(gl);
                grants_reg <= grants_reg + 32'h1;
            end
        end
    end

    // datavalid may arrive in the same cycle as a new read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_reg + ((am_rd && !am_waitreq) ? PW'(am_burstcount) : PW'(0))
                        - (am_datavalid ? PW'(1) : PW'(0));
        end
    end

    // all scheduler state returns idle on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int l = 0; l < MFE_LEVELS; l++) begin
                samp_reg[l] <= '0;
                cnt_reg[l] <= '0;
                boost_reg[l] <= '0;
            end
        end else if (grant) begin
            samp_reg[best_lvl] <= batch_sel & ~sel_oh;
            for (int l = 1; l < MFE_LEVELS; l++) begin
                if (3'(l) == best_lvl) begin
                    cnt_reg[l] <= '0;
                    boost_reg[l] <= '0;
                end else if (starv_en_reg[l-1] && (elig & lvl_mask[l]) != '0) begin
                    // only a waiting, enabled level counts
                    if (cnt_reg[l] + MFE_LIM_W'(1) >= limit_reg[(l-1)*MFE_LIM_W +: MFE_LIM_W]) begin
                        cnt_reg[l] <= '0;
                        if (boost_reg[l] < MFE_BOOST_W'(l)) begin
                            boost_reg[l] <= boost_reg[l] + MFE_BOOST_W'(1);
                        end
                    end else begin
                        cnt_reg[l] <= cnt_reg[l] + MFE_LIM_W'(1);
                    end
                end else if (!starv_en_reg[l-1]) begin
                    cnt_reg[l] <= '0;
                    boost_reg[l] <= '0;
                end
            end
        end
    end

    // one wait state; writes land at the edge pready is seen
    assign apb_acc = psel && penable && !pready;
    assign apb_done = psel && penable && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_acc;
            if (apb_acc) begin
                pslverr <= 1'b0;
                prdata <= '0;
                if (paddr[7:0] == MFE_OFF_STARV_EN) begin
                    prdata <= {27'h0, starv_en_reg, 1'b0};
                end else if (paddr[7:0] == MFE_OFF_LIMIT) begin
                    prdata <= limit_reg;
                end else if (paddr[7:0] == MFE_OFF_STATUS) begin
                    prdata <= {14'h0, state_reg, 16'(pend_reg)};
                end else if (paddr[7:0] == MFE_OFF_GRANTS) begin
                    prdata <= grants_reg;
                end else if (paddr[7:0] != MFE_OFF_FLUSH || paddr[31:8] != '0) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // flush bits clear themselves after one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            starv_en_reg <= MFE_STARV_EN_RST;
            limit_reg <= MFE_LIMIT_RST;
            port_flush <= '0;
        end else begin
            port_flush <= '0;
            if (apb_done && pwrite && paddr[31:8] == '0) begin
                if (paddr[7:0] == MFE_OFF_FLUSH) begin
                    port_flush <= pwdata[NPORTS-1:0] & cached;
                end else if (paddr[7:0] == MFE_OFF_STARV_EN) begin
                    starv_en_reg <= pwdata[4:1]; // level 0 has none
                end else if (paddr[7:0] == MFE_OFF_LIMIT) begin
                    limit_reg <= pwdata;
                end
            end
        end
    end

    property p_pend_max;
        @(posedge pclk) disable iff (!presetn) int'(pend_reg) <= MAX_PEND;
    endproperty
    a_pend_max: assert property (p_pend_max) else $error("too many reads");

    property p_wr_half;
        @(posedge pclk) disable iff (!presetn)
            (am_wr && am_burststart) |-> int'(am_burstcount) <= HALF_BUF;
    endproperty
    a_wr_half: assert property (p_wr_half) else $error("write burst not split");

    property p_aligned;
        @(posedge pclk) disable iff (!presetn)
            (am_rd || am_wr) |-> am_addr[MBL-1:0] == '0;
    endproperty
    a_aligned: assert property (p_aligned) else $error("master address unaligned");

    property p_align_wait;
        @(posedge pclk) disable iff (!presetn)
            (state_reg == MFE_ST_ALIGN && fill_reg > LW'(1))
            |-> port_waitreq != '0 ##1 (state_reg == MFE_ST_ALIGN && port_waitreq != '0);
    endproperty
    a_align_wait: assert property (p_align_wait) else $error("filler without wait");

    property p_align_end;
        @(posedge pclk) disable iff (!presetn)
            (state_reg == MFE_ST_ALIGN && fill_reg == LW'(1))
            |=> (state_reg == MFE_ST_CMD && am_wr && am_burststart && port_waitreq == '0);
    endproperty
    a_align_end: assert property (p_align_end) else $error("filler count wrong");

    property p_flush;
        @(posedge pclk) disable iff (!presetn)
            (apb_done && pwrite && paddr == 32'(MFE_OFF_FLUSH))
            |=> (port_flush == ($past(pwdata[NPORTS-1:0]) & cached)) ##1 port_flush == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong");

    property p_top_level;
        @(posedge pclk) disable iff (!presetn) boost_reg[0] == '0 && cnt_reg[0] == '0;
    endproperty
    a_top_level: assert property (p_top_level) else $error("top level boosted");

    property p_no_starv;
        @(posedge pclk) disable iff (!presetn)
            (!starv_en_reg[3] && grant) |=> boost_reg[4] == '0;
    endproperty
    a_no_starv: assert property (p_no_starv) else $error("boost while disabled");

    property p_grant_one;
        @(posedge pclk) disable iff (!presetn)
            $onehot0(port_grant) && (port_grant == '0 || $past(state_reg) == MFE_ST_IDLE);
    endproperty
    a_grant_one: assert property (p_grant_one) else $error("bad grant");
endmodule

/* mfe_mem_model.sv */
`timescale 1ns/1ps
module mfe_mem_model #(
    parameter int LW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic am_rd,
    input wire logic am_wr,
    input wire logic [LW-1:0] am_burstcount,
    output logic am_waitreq,
    output logic am_datavalid
);
    logic [15:0] owed_reg;
    logic [3:0] tick_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + 4'h1;
        end
    end
    // stall three of four cycles when slow, so progress never stops
    assign am_waitreq = slow && (tick_reg[1:0] != 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owed_reg <= '0;
        end else begin
            owed_reg <= owed_reg + ((am_rd && !am_waitreq) ? 16'(am_burstcount) : 16'h0)
                - (am_datavalid ? 16'h1 : 16'h0);
        end
    end
    // read words come back one per cycle, or every other cycle when slow
    assign am_datavalid = (owed_reg != 16'h0) && !(slow && tick_reg[0]);
endmodule

/* mfe_pkg.sv */
package mfe_pkg;
    localparam int MFE_LEVELS = 5;
    localparam int MFE_MAX_PORTS = 26;
    localparam int MFE_AW_MIN = 8;
    localparam int MFE_AW_MAX = 40;
    localparam int MFE_LIM_W = 8;
    localparam int MFE_BOOST_W = 3;
    localparam logic [7:0] MFE_OFF_FLUSH = 8'h00;
    localparam logic [7:0] MFE_OFF_STARV_EN = 8'h04;
    localparam logic [7:0] MFE_OFF_LIMIT = 8'h08;
    localparam logic [7:0] MFE_OFF_STATUS = 8'h0c;
    localparam logic [7:0] MFE_OFF_GRANTS = 8'h10;
    localparam logic [3:0] MFE_STARV_EN_RST = 4'h0;
    localparam logic [31:0] MFE_LIMIT_RST = 32'h30303030;
    localparam logic [1:0] MFE_PT_NONE = 2'h0;
    localparam logic [1:0] MFE_PT_CACHED = 2'h1;
    localparam logic [1:0] MFE_PT_BURST = 2'h2;
    typedef enum logic [1:0] {
        MFE_ST_IDLE = 2'b00,
        MFE_ST_ALIGN = 2'b01,
        MFE_ST_CMD = 2'b10
    } mfe_state_e;
endpackage

/* tb_mfe_front_end.sv */
`timescale 1ns/1ps
module tb_mfe_front_end;
    import mfe_pkg::*;
    localparam int NP = 4;
    localparam int LW = 8;
    localparam int BUF = 64;
    localparam int MP = 16;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, am_addr, cmd_addr;
    logic pready, pslverr, am_rd, am_wr, am_burststart, am_waitreq, am_datavalid;
    logic [NP-1:0] port_req = '0, port_rd = '0, port_hit = 4'h4;
    logic [NP-1:0] port_grant, port_waitreq, port_flush, fl_acc;
    logic [NP*32-1:0] port_addr = '0;
    logic [NP*LW-1:0] port_len = '0, port_room = '0;
    logic [LW-1:0] port_chunk, am_burstcount, cmd_bc;
    int err_total = 0, check_count = 0, cyc = 0, owed = 0, wq = 0, nrd = 0;
    int rem [NP] = '{default: 0};
    bit req_on [NP] = '{default: 0}, rd_v [NP] = '{default: 0}, seen [NP] = '{default: 0};
    logic [LW-1:0] room [NP] = '{default: 8'h01}, first_chunk [NP];
    logic [31:0] addr_v [NP] = '{default: 32'h0};
    int glog [$];
    logic [15:0] lfsr = 16'h7456;
    mfe_front_end #(.NPORTS(NP), .LW(LW), .BUF_WORDS(BUF), .MAX_PEND(MP),
        .PORT_TYPE(8'h9a), .PORT_LEVEL(12'h301), .PORT_RATIO(8'h80), .DOUBLE_W(4'h4),
        .FORCE_RELOAD(4'h4)) mfe_front_end_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_req(port_req), .port_rd(port_rd),
        .port_hit(port_hit), .port_addr(port_addr), .port_len(port_len), .port_room(port_room),
        .port_grant(port_grant), .port_chunk(port_chunk), .port_waitreq(port_waitreq),
        .port_flush(port_flush), .am_addr(am_addr), .am_rd(am_rd), .am_wr(am_wr),
        .am_burstcount(am_burstcount), .am_burststart(am_burststart),
        .am_waitreq(am_waitreq), .am_datavalid(am_datavalid));
    mfe_mem_model #(.LW(LW)) mfe_mem_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
        .am_rd(am_rd), .am_wr(am_wr), .am_burstcount(am_burstcount), .am_waitreq(am_waitreq),
        .am_datavalid(am_datavalid));
    always #5 pclk = ~pclk;
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input bit wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // port requests live in tb variables, turned into pins at the next edge
    task automatic go(input int p, input bit r, input logic [31:0] a, input int n,
                      input logic [LW-1:0] rm);
        rd_v[p] = r;
        addr_v[p] = a;
        room[p] = rm;
        rem[p] = n;
        seen[p] = 1'b0;
        req_on[p] = 1'b1;
    endtask
    task automatic wait_idle(input int p);
        while (rem[p] > 0 && req_on[p]) @(posedge pclk);
        req_on[p] = 1'b0;
        @(posedge pclk);
        while (am_rd || am_wr || port_waitreq != 0 || owed != 0) @(posedge pclk);
    endtask
    task automatic run(input int p, input bit r, input logic [31:0] a, input int n,
                       input logic [LW-1:0] rm);
        @(negedge pclk);
        go(p, r, a, n, rm);
        wait_idle(p);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            tally_and_finish();
        end
        fl_acc = fl_acc | port_flush;
        if (port_waitreq[3]) wq++;
        if (am_burststart && (am_rd || am_wr) && !am_waitreq) begin
            cmd_addr = am_addr;
            cmd_bc = am_burstcount;
            chk(32'(am_addr[2:0]), 32'h0);
            if (am_rd) nrd++;
        end
        if (am_rd && !am_waitreq) owed += int'(am_burstcount);
        if (am_datavalid) owed--;
        if (!presetn) owed = 0;
        if (am_rd || owed != 0) chk(32'(owed <= MP), 32'h1);
        for (int i = 0; i < NP; i++) begin
            if (port_grant[i]) begin
                chk(32'(port_chunk != 0 && int'(port_chunk) <= rem[i]), 32'h1);
                if (!seen[i]) first_chunk[i] = port_chunk;
                seen[i] = 1'b1;
                rem[i] -= int'(port_chunk);
                glog.push_back(i);
            end
            port_req[i] <= req_on[i] && rem[i] > 0;
            port_rd[i] <= rd_v[i];
            port_addr[i*32 +: 32] <= addr_v[i];
            port_len[i*LW +: LW] <= LW'(rem[i] > 0 ? rem[i] : 0);
            port_room[i*LW +: LW] <= room[i];
        end
    end
    initial begin
        logic [31:0] d;
        logic e;
        int c;
        logic [LW-1:0] rm;
        fl_acc = '0;
        repeat (5) @(posedge pclk);
        chk(32'({am_rd, am_wr, port_grant, port_flush, pready}), 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 32'(MFE_OFF_LIMIT), 32'h0, d, e);
        chk(d, MFE_LIMIT_RST);
        apb(1'b1, 32'(MFE_OFF_STARV_EN), 32'hffffffff, d, e);
        apb(1'b0, 32'(MFE_OFF_STARV_EN), 32'h0, d, e);
        chk(d, 32'h1e);
        apb(1'b1, 32'(MFE_OFF_STARV_EN), 32'(MFE_STARV_EN_RST), d, e);
        apb(1'b0, 32'h40, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
        apb(1'b1, 32'(MFE_OFF_FLUSH), 32'h5, d, e);
        repeat (8) @(posedge pclk);
        chk(32'(fl_acc), 32'h4);
        $display("test registers done");
        c = nrd;
        run(2, 1'b1, 32'h400, 4, 8'h08);
        chk(32'(nrd > c), 32'h1);
        chk(32'(cmd_bc), 32'h8);
        run(1, 1'b1, 32'h1000, 20, 8'h05);
        chk(32'(first_chunk[1]), 32'h5);
        chk(32'(cmd_bc), 32'h5);
        run(1, 1'b0, 32'h2000, 40, 8'h01);
        chk(32'(first_chunk[1] <= BUF / 2), 32'h1);
        wq = 0;
        run(3, 1'b0, 32'h100, 8, 8'h01);
        chk(wq, 0);
        chk(32'(cmd_bc), 32'h2);
        wq = 0;
        run(3, 1'b0, 32'h102, 6, 8'h01);
        chk(wq, 2);
        chk(cmd_addr, 32'h100);
        chk(32'(cmd_bc), 32'h2);
        $display("test packing done");
        glog.delete();
        @(negedge pclk);
        go(0, 1'b0, 32'h3000, 80, 8'h01);
        go(3, 1'b0, 32'h4000, 200, 8'h01);
        wait_idle(0);
        wait_idle(3);
        for (c = 0; c < 4; c++) chk(glog[c], (c % 2 == 0) ? 0 : 3);
        glog.delete();
        @(negedge pclk);
        go(0, 1'b0, 32'h500, 4, 8'h01);
        go(1, 1'b1, 32'h0, 255, 8'h01);
        go(2, 1'b0, 32'h300, 4, 8'h01);
        while (glog.size() < 30) @(posedge pclk);
        chk(glog[0], 1);
        chk(32'(glog.sum() with (int'(item != 1))), 32'h0);
        @(negedge pclk);
        req_on[1] = 1'b0;
        wait_idle(0);
        wait_idle(2);
        $display("test priority done");
        apb(1'b1, 32'(MFE_OFF_STARV_EN), 32'h10, d, e);
        apb(1'b1, 32'(MFE_OFF_LIMIT), 32'h02303030, d, e);
        glog.delete();
        @(negedge pclk);
        go(1, 1'b1, 32'h0, 255, 8'h01);
        go(2, 1'b0, 32'h300, 4, 8'h01);
        while (!seen[2]) @(posedge pclk);
        for (c = 0; c < glog.size() && glog[c] != 2; c++) begin
        end
        chk(c, 8);
        // reset lands while port 1 still streams reads
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'({am_rd, am_wr, port_grant, port_waitreq}), 32'h0);
        presetn <= 1'b1;
        apb(1'b0, 32'(MFE_OFF_STARV_EN), 32'h0, d, e);
        chk(d, 32'h0);
        req_on[1] = 1'b0;
        wait_idle(1);
        $display("test starvation done");
        for (int k = 0; k < 12; k++) begin
            lfsr = step(lfsr);
            slow <= lfsr[1];
            rm = 8'(1 + lfsr[7:4]);
            run(1, lfsr[0], {13'h0, lfsr, 3'h0}, 1 + int'(lfsr[13:8]) % 40, rm);
            if (lfsr[0]) chk(32'(first_chunk[1] <= rm), 32'h1);
        end
        $display("test random done");
        tally_and_finish();
    end
endmodule
